// ==== rtl/ptrl_top.sv ====
// Purpose: palette test register: selector, id, ones accumulation, analog test
// Assumes: i_mclk is the pixel clock; video pins are synchronised here
// Notes: registers reached over Avalon-MM with waitrequest
//
// Summary of operation
// - three-bit selector picks palette, identification, accumulation or analog channel
// - write loads selector; read returns data of the selected channel
// - palette reads advance red, green, blue, then wrap to red
// - identification value is constant, readable any time
// - identification read moves selector to red; back only by writing again
// - after writing 011 six reads give id, red, green, blue, red, green
// - codes 100, 101, 110 monitor red, green, blue palette byte
// - count all eight one bits of monitored byte into accumulator
// - same colour byte monitored for whole frame
// - accumulator saturates at 255
// - accumulation samples only every second pixel
// - frame sync fall copies accumulator to result, then clears it
// - result changes only on frame sync fall
// - before next frame selector changes to another accumulation colour
// - pixel phase fixed across frames, restarts only on reset
// - compare select bits loaded by every selector write, read back only with 111
// - bit 3 is read-only comparison result
// - 1010 red vs blue, 1001 red vs reference, 1 means red greater
// - 0110 green vs blue, 0101 green vs reference, 1 means green greater
// - result latched on falling edge of strobe from blanking
`timescale 1ns/1ps
module ptrl_top
	import ptrl_pkg::*;
#(
	parameter int DATA_W = 8
)(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [7:0] i_pal_red,
	input wire logic [7:0] i_pal_green,
	input wire logic [7:0] i_pal_blue,
	input wire logic i_frame_sync_n,
	input wire logic i_blank_n,
	input wire logic i_cmp_red_gt_blue,
	input wire logic i_cmp_red_gt_ref,
	input wire logic i_cmp_green_gt_blue,
	input wire logic i_cmp_green_gt_ref,
	output logic [3:0] o_cmp_select
);
	generate
		if (DATA_W != 8)
		begin : g_bad_width
			$error("DATA_W must be 8");
		end
	endgenerate

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	logic [1:0] vs_sync_reg;
	logic [1:0] bl_sync_reg;
	logic [3:0] cmp_s1_reg;
	logic [3:0] cmp_s2_reg;
	logic vs_prev_reg;
	logic bl_prev_reg;
	logic vs_fall;
	logic bl_fall;

	// two flops per pin, then a history flop for edges
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			vs_sync_reg <= 2'b11;
			bl_sync_reg <= 2'b11;
			cmp_s1_reg <= 4'h0;
			cmp_s2_reg <= 4'h0;
			vs_prev_reg <= 1'b1;
			bl_prev_reg <= 1'b1;
		end
		else
		begin
			vs_sync_reg <= {vs_sync_reg[0], i_frame_sync_n};
			bl_sync_reg <= {bl_sync_reg[0], i_blank_n};
			cmp_s1_reg <= {i_cmp_green_gt_ref, i_cmp_green_gt_blue,
				i_cmp_red_gt_ref, i_cmp_red_gt_blue};
			cmp_s2_reg <= cmp_s1_reg;
			vs_prev_reg <= vs_sync_reg[1];
			bl_prev_reg <= bl_sync_reg[1];
		end
	end

	assign vs_fall = vs_prev_reg & ~vs_sync_reg[1]; // only pin edge counts
	assign bl_fall = bl_prev_reg & ~bl_sync_reg[1];

	// --------------------------------------------------------------
	// bus slave
	// --------------------------------------------------------------
	ptrl_bus_t bus_state_reg;
	logic [2:0] sel_reg;
	logic [3:0] cmpsel_reg;
	logic result_reg;
	logic [7:0] acc_tmp_reg;
	logic [7:0] acc_red_reg;
	logic [7:0] acc_green_reg;
	logic [7:0] acc_blue_reg;
	logic phase_reg;
	logic bus_take;
	logic rd_test;
	logic wr_test;

	assign bus_take = (i_avs_read | i_avs_write) && bus_state_reg == PTRL_BUS_IDLE;
	assign rd_test = bus_take && i_avs_read && i_avs_address == PTRL_OFS_TEST;
	assign wr_test = bus_take && i_avs_write && i_avs_address == PTRL_OFS_TEST;

	// popcount of one palette byte
	function automatic logic [3:0] ones_of(input logic [7:0] b);
		logic [3:0] n;
		n = 4'h0;
		for (int k = 0; k < 8; k++)
		begin
			n = n + {3'h0, b[k]};
		end
		return n;
	endfunction

	// next palette channel with wrap
	function automatic logic [2:0] pal_next(input logic [2:0] s);
		logic [2:0] r;
		r = PTRL_CH_PAL_RED;
		if (s == PTRL_CH_PAL_RED)
			r = PTRL_CH_PAL_GREEN;
		else if (s == PTRL_CH_PAL_GREEN)
			r = PTRL_CH_PAL_BLUE;
		return r;
	endfunction

	// data word for the selected channel
	function automatic logic [7:0] chan_data(input logic [2:0] s, input logic [7:0] r,
		input logic [7:0] g, input logic [7:0] b, input logic [7:0] ar,
		input logic [7:0] ag, input logic [7:0] ab);
		logic [7:0] d;
		d = 8'h00;
		case (s)
			PTRL_CH_PAL_RED: d = r;
			PTRL_CH_PAL_GREEN: d = g;
			PTRL_CH_PAL_BLUE: d = b;
			PTRL_CH_IDENT: d = PTRL_IDENT_VALUE;
			PTRL_CH_ACC_RED: d = ar;
			PTRL_CH_ACC_GREEN: d = ag;
			PTRL_CH_ACC_BLUE: d = ab;
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	// answer one cycle after the request is seen; then release
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			bus_state_reg <= PTRL_BUS_IDLE;
			o_avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			case (bus_state_reg)
				PTRL_BUS_IDLE:
				begin
					if (bus_take)
						bus_state_reg <= PTRL_BUS_DONE;
					if (rd_test)
						o_avs_readdata <= {24'h00_0000, (sel_reg == PTRL_CH_ANALOG) ?
							{cmpsel_reg, result_reg, sel_reg} :
							chan_data(sel_reg, i_pal_red, i_pal_green, i_pal_blue,
							acc_red_reg, acc_green_reg, acc_blue_reg)};
					else if (bus_take && i_avs_read && i_avs_address == PTRL_OFS_STATUS)
						o_avs_readdata <= {24'h00_0000, acc_tmp_reg};
					else if (bus_take)
						o_avs_readdata <= 32'h0000_0000;
				end
				default:
					bus_state_reg <= PTRL_BUS_IDLE;
			endcase
		end
	end

	// waitrequest high except in the answer cycle
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			o_avs_waitrequest <= 1'b1;
		else
			o_avs_waitrequest <= ~bus_take;
	end

	// --------------------------------------------------------------
	// selector and compare select
	// --------------------------------------------------------------
	logic frame_adv;
	assign frame_adv = vs_fall && sel_reg[2] && sel_reg != PTRL_CH_ANALOG;

	// host write wins; otherwise read post-increment or frame rotation
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			sel_reg <= PTRL_SEL_RST;
			cmpsel_reg <= PTRL_CMPSEL_RST;
		end
		else if (wr_test)
		begin
			sel_reg <= i_avs_writedata[PTRL_SEL_LSB +: 3];
			cmpsel_reg <= i_avs_writedata[PTRL_CMP_LSB +: 4];
		end
		else if (rd_test && sel_reg == PTRL_CH_IDENT)
			sel_reg <= PTRL_CH_PAL_RED;
		else if (rd_test && !sel_reg[2] && sel_reg != PTRL_CH_IDENT)
			sel_reg <= pal_next(sel_reg);
		else if (frame_adv)
			sel_reg <= (sel_reg == PTRL_CH_ACC_BLUE) ? PTRL_CH_ACC_RED :
				sel_reg + 3'h1;
	end

	// compare select to the analog side, new value in the write cycle
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			o_cmp_select <= PTRL_CMPSEL_RST;
		else
			o_cmp_select <= wr_test ? i_avs_writedata[PTRL_CMP_LSB +: 4] : cmpsel_reg;
	end

	// --------------------------------------------------------------
	// ones accumulation
	// --------------------------------------------------------------
	logic [7:0] mon_byte;
	logic [8:0] acc_sum;
	assign mon_byte = (sel_reg == PTRL_CH_ACC_GREEN) ? i_pal_green :
		(sel_reg == PTRL_CH_ACC_BLUE) ? i_pal_blue : i_pal_red;
	assign acc_sum = {1'b0, acc_tmp_reg} + {5'h00, ones_of(mon_byte)};

	// free-running half-rate phase, restarts only on reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			phase_reg <= 1'b0;
		else
			phase_reg <= ~phase_reg;
	end

	// accumulate on sampled pixels; frame sync fall transfers and clears
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			acc_tmp_reg <= PTRL_ACC_RST;
			acc_red_reg <= PTRL_ACC_RST;
			acc_green_reg <= PTRL_ACC_RST;
			acc_blue_reg <= PTRL_ACC_RST;
		end
		else if (vs_fall)
		begin
			acc_tmp_reg <= PTRL_ACC_RST;
			if (sel_reg == PTRL_CH_ACC_RED)
				acc_red_reg <= acc_tmp_reg;
			else if (sel_reg == PTRL_CH_ACC_GREEN)
				acc_green_reg <= acc_tmp_reg;
			else if (sel_reg == PTRL_CH_ACC_BLUE)
				acc_blue_reg <= acc_tmp_reg;
		end
		else if (phase_reg && sel_reg[2] && sel_reg != PTRL_CH_ANALOG)
			acc_tmp_reg <= acc_sum[8] ? 8'hFF : acc_sum[7:0];
	end

	// --------------------------------------------------------------
	// analog comparison result
	// --------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			result_reg <= 1'b0;
		else if (bl_fall)
		begin
			case (cmpsel_reg)
				PTRL_CMP_R_B: result_reg <= cmp_s2_reg[0];
				PTRL_CMP_R_REF: result_reg <= cmp_s2_reg[1];
				PTRL_CMP_G_B: result_reg <= cmp_s2_reg[2];
				PTRL_CMP_G_REF: result_reg <= cmp_s2_reg[3];
				default: result_reg <= 1'b0;
			endcase
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	sequence s_id_read;
		rd_test && sel_reg == PTRL_CH_IDENT;
	endsequence

	// waitrequest low for exactly one cycle after a take
	sequence s_answer;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence

	a_id_to_red: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		s_id_read |=> sel_reg == PTRL_CH_PAL_RED)
		else $error("id read did not move to red");
	a_blue_wrap: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		rd_test && sel_reg == PTRL_CH_PAL_BLUE |=> sel_reg == PTRL_CH_PAL_RED)
		else $error("blue did not wrap to red");
	a_acc_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		vs_fall |=> acc_tmp_reg == PTRL_ACC_RST)
		else $error("accumulator not cleared");
	a_acc_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!vs_fall |=> $stable(acc_red_reg) && $stable(acc_green_reg)
		&& $stable(acc_blue_reg))
		else $error("result changed without frame sync");
	a_acc_sat: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		acc_tmp_reg == 8'hFF && !vs_fall |=> acc_tmp_reg == 8'hFF)
		else $error("accumulator wrapped");
	a_half_rate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!phase_reg && !vs_fall |=> $stable(acc_tmp_reg))
		else $error("accumulated on skipped pixel");
	a_frame_rotate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		frame_adv && !rd_test && !wr_test && sel_reg == PTRL_CH_ACC_BLUE
		|=> sel_reg == PTRL_CH_ACC_RED)
		else $error("rotation did not wrap");
	a_result_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!bl_fall |=> $stable(result_reg))
		else $error("result changed off strobe");
	a_answer_pulse: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		bus_take |=> s_answer)
		else $error("answer cycle not one cycle long");
	a_id_select: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		wr_test && i_avs_writedata[PTRL_SEL_LSB +: 3] == PTRL_CH_IDENT |=> sel_reg == PTRL_CH_IDENT)
		else $error("id write did not select id");
	a_monitor_fixed: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		rd_test && sel_reg[2] && !vs_fall |=> $stable(sel_reg))
		else $error("read moved accumulation channel");
endmodule

// ==== rtl/ptrl_pkg.sv ====
// Purpose: constants for the palette test register logic
// Assumes: one clock, Avalon-MM register access
// Notes: identification value is arbitrary
package ptrl_pkg;
	// register map (byte addresses)
	localparam logic [3:0] PTRL_OFS_TEST = 4'h0;
	localparam logic [3:0] PTRL_OFS_STATUS = 4'h4;
	// channel selector codes
	localparam logic [2:0] PTRL_CH_PAL_RED = 3'h0;
	localparam logic [2:0] PTRL_CH_PAL_GREEN = 3'h1;
	localparam logic [2:0] PTRL_CH_PAL_BLUE = 3'h2;
	localparam logic [2:0] PTRL_CH_IDENT = 3'h3;
	localparam logic [2:0] PTRL_CH_ACC_RED = 3'h4;
	localparam logic [2:0] PTRL_CH_ACC_GREEN = 3'h5;
	localparam logic [2:0] PTRL_CH_ACC_BLUE = 3'h6;
	localparam logic [2:0] PTRL_CH_ANALOG = 3'h7;
	// field positions
	localparam int PTRL_SEL_LSB = 0;
	localparam int PTRL_RES_BIT = 3;
	localparam int PTRL_CMP_LSB = 4;
	// compare select codes
	localparam logic [3:0] PTRL_CMP_NONE = 4'h0;
	localparam logic [3:0] PTRL_CMP_R_B = 4'hA;
	localparam logic [3:0] PTRL_CMP_R_REF = 4'h9;
	localparam logic [3:0] PTRL_CMP_G_B = 4'h6;
	localparam logic [3:0] PTRL_CMP_G_REF = 4'h5;
	// reset values
	localparam logic [2:0] PTRL_SEL_RST = 3'h0;
	localparam logic [3:0] PTRL_CMPSEL_RST = 4'h0;
	localparam logic [7:0] PTRL_ACC_RST = 8'h00;
	// arbitrary identification value
	localparam logic [7:0] PTRL_IDENT_VALUE = 8'h5A;
	// bus answer state
	typedef enum logic [1:0] {
		PTRL_BUS_IDLE = 2'b01,
		PTRL_BUS_DONE = 2'b10
	} ptrl_bus_t;
endpackage

// ==== test/ptrl_host.sv ====
// Purpose: host processor model reaching the test register over Avalon-MM
// Assumes: one request at a time, answer awaited without a cycle count
// Notes: bench scenarios call the tasks hierarchically
`timescale 1ns/1ps
module ptrl_host
	import ptrl_pkg::*;
(
	input wire logic i_mclk,
	input wire logic [31:0] i_readdata,
	input wire logic i_waitrequest,
	output logic [3:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata
);
	// idle bus at time zero
	initial
	begin
		o_address = 4'h0;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
	end

	// one transfer, held until waitrequest is seen low at an edge
	task automatic xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge i_mclk);
		o_address <= adr;
		o_write <= wr;
		o_read <= ~wr;
		o_writedata <= wd;
		do
			@(posedge i_mclk);
		while (i_waitrequest !== 1'b0);
		rd = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
		// released data no longer shows the last value
		o_writedata <= ~wd;
	endtask

	// selector write; compare bits zero except on the analog channel
	task automatic put_sel(input logic [2:0] sel, input logic [3:0] cmp);
		logic [31:0] unused;
		xfer(1'b1, PTRL_OFS_TEST, {24'h00_0000, (sel == PTRL_CH_ANALOG) ? cmp : PTRL_CMP_NONE,
			1'b0, sel}, unused);
	endtask
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the palette test register logic
// Assumes: host model drives the register bus, bench drives video pins
// Notes: expectations come from package constants and chosen stimulus
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		checks++; \
		if ((got) !== (ex)) \
		begin \
			err_total++; \
			$display("mismatch %s expected %h seen %h", nm, ex, got); \
		end \
	end
module tb_top
	import ptrl_pkg::*;
;
	logic i_mclk;
	logic i_rstn;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] pal_r, pal_g, pal_b;
	logic frame_sync_n;
	logic blank_n;
	logic [3:0] cmp_vec;
	logic [3:0] cmp_sel;
	int err_total = 0;
	int checks = 0;

	// ----------------------------------------
	// design, host model, clock
	// ----------------------------------------
	ptrl_top u_ptrl_top (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.i_pal_red(pal_r), .i_pal_green(pal_g), .i_pal_blue(pal_b),
		.i_frame_sync_n(frame_sync_n), .i_blank_n(blank_n),
		.i_cmp_red_gt_blue(cmp_vec[3]), .i_cmp_red_gt_ref(cmp_vec[2]),
		.i_cmp_green_gt_blue(cmp_vec[1]), .i_cmp_green_gt_ref(cmp_vec[0]),
		.o_cmp_select(cmp_sel));
	ptrl_host u_ptrl_host (.i_mclk(i_mclk), .i_readdata(avs_readdata),
		.i_waitrequest(avs_waitrequest), .o_address(avs_address), .o_read(avs_read),
		.o_write(avs_write), .o_writedata(avs_writedata));
	always #25 i_mclk = ~i_mclk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic rd_chk(input logic [3:0] adr, input logic [31:0] ex, input string nm);
		logic [31:0] q;
		u_ptrl_host.xfer(1'b0, adr, 32'h0000_0000, q);
		`CHK(nm, ex, q)
	endtask

	// one frame: quiet margins round 2k pixels of bytes, then sync fall
	task automatic frame(input int k, input logic [7:0] r, input logic [7:0] g,
		input logic [7:0] b);
		repeat (10) @(posedge i_mclk);
		pal_r <= r;
		pal_g <= g;
		pal_b <= b;
		repeat (2 * k) @(posedge i_mclk);
		pal_r <= 8'h00;
		pal_g <= 8'h00;
		pal_b <= 8'h00;
		repeat (10) @(posedge i_mclk);
		frame_sync_n <= 1'b0;
		repeat (4) @(posedge i_mclk);
		frame_sync_n <= 1'b1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ident();
		logic [7:0] seq [6];
		logic [31:0] q;
		seq = '{PTRL_IDENT_VALUE, pal_r, pal_g, pal_b, pal_r, pal_g};
		u_ptrl_host.put_sel(PTRL_CH_IDENT, PTRL_CMP_NONE);
		for (int i = 0; i < 6; i++)
			rd_chk(PTRL_OFS_TEST, {24'h00_0000, seq[i]}, "id sequence");
		// a stray write elsewhere must not reselect the id
		u_ptrl_host.xfer(1'b1, 4'h8, 32'h0000_0003, q);
		rd_chk(PTRL_OFS_TEST, {24'h00_0000, pal_b}, "no id return");
		rd_chk(4'h8, 32'h0000_0000, "unmapped read");
	endtask

	task automatic t_analog();
		logic [3:0] code [4];
		logic [31:0] q;
		code = '{PTRL_CMP_R_B, PTRL_CMP_R_REF, PTRL_CMP_G_B, PTRL_CMP_G_REF};
		for (int i = 0; i < 8; i++)
		begin
			// matching comparator high on even passes, low on odd, held steady
			cmp_vec <= (i % 2 == 0) ? (4'h8 >> (i / 2)) : ~(4'h8 >> (i / 2));
			u_ptrl_host.put_sel(PTRL_CH_ANALOG, code[i / 2]);
			@(posedge i_mclk);
			`CHK("compare select", code[i / 2], cmp_sel)
			blank_n <= 1'b0;
			repeat (8) @(posedge i_mclk);
			blank_n <= 1'b1;
			rd_chk(PTRL_OFS_TEST, {24'h00_0000, code[i / 2], i % 2 == 0, PTRL_CH_ANALOG},
				"analog result");
		end
		// a written one in bit 3 must not reach the result
		u_ptrl_host.xfer(1'b1, PTRL_OFS_TEST,
			{24'h00_0000, PTRL_CMP_G_REF, 1'b1, PTRL_CH_ANALOG}, q);
		rd_chk(PTRL_OFS_TEST, {24'h00_0000, PTRL_CMP_G_REF, 1'b0, PTRL_CH_ANALOG},
			"result read only");
		u_ptrl_host.put_sel(PTRL_CH_PAL_RED, PTRL_CMP_NONE);
		@(posedge i_mclk);
		`CHK("compare select idle", PTRL_CMP_NONE, cmp_sel)
	endtask

	// 20 samples of 2, 3, 4 ones; rotation green, blue, red after flush
	task automatic t_accum();
		u_ptrl_host.put_sel(PTRL_CH_ACC_RED, PTRL_CMP_NONE);
		frame(0, 8'h00, 8'h00, 8'h00);
		repeat (3) frame(20, 8'h41, 8'h07, 8'h0F);
		u_ptrl_host.put_sel(PTRL_CH_ACC_GREEN, PTRL_CMP_NONE);
		rd_chk(PTRL_OFS_TEST, 32'h0000_003C, "green ones");
		u_ptrl_host.put_sel(PTRL_CH_ACC_GREEN, PTRL_CMP_NONE);
		// 40 samples of 8 ones exceed the ceiling
		frame(40, 8'hFF, 8'hFF, 8'hFF);
		rd_chk(PTRL_OFS_STATUS, 32'h0000_0000, "temp cleared");
		u_ptrl_host.put_sel(PTRL_CH_ACC_RED, PTRL_CMP_NONE);
		rd_chk(PTRL_OFS_TEST, 32'h0000_0028, "red ones");
		u_ptrl_host.put_sel(PTRL_CH_ACC_GREEN, PTRL_CMP_NONE);
		rd_chk(PTRL_OFS_TEST, 32'h0000_00FF, "green saturated");
		u_ptrl_host.put_sel(PTRL_CH_ACC_BLUE, PTRL_CMP_NONE);
		rd_chk(PTRL_OFS_TEST, 32'h0000_0050, "blue ones");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		i_mclk = 1'b0;
		i_rstn = 1'b0;
		pal_r = 8'h3C;
		pal_g = 8'hA5;
		pal_b = 8'h0F;
		frame_sync_n = 1'b1;
		blank_n = 1'b1;
		cmp_vec = 4'h0;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		rd_chk(PTRL_OFS_TEST, {24'h00_0000, pal_r}, "reset palette red");
		t_ident();
		t_analog();
		t_accum();
		give_verdict();
	end

	// cuts a hang well past the expected few hundred cycles
	initial
	begin
		repeat (8000) @(posedge i_mclk);
		err_total++;
		give_verdict();
	end
endmodule
